// File: hw/acr_config_regs.sv
/*
  Configuration registers of a delta-sigma sensor converter: rate and mode,
  reference, line-rejection filter, low-side switch, excitation current and
  its routing, and data-ready signalling.
  Assumes the serial port delivers decoded write and read strobes with an
  address and byte, and that command pulses and i_conv_tick are synchronous.
*/
`timescale 1ns/1ps
module acr_config_regs
  import acr_pkg::*;
#(
  parameter int RATE_DIV = 1           // Divides sample periods for simulation.
) (
  input wire logic i_clk,              // System clock, 200 MHz.
  input wire logic i_sys_rst,          // Synchronous reset, active high.
  input wire logic i_reg_wr,           // Register write strobe.
  input wire logic i_reg_rd,           // Register read strobe.
  input wire logic [1:0] i_reg_addr,   // Register offset.
  input wire logic [7:0] i_reg_wdata,  // Write byte.
  output logic [7:0] o_reg_rdata,      // Read byte, valid after a read.
  input wire logic i_start_cmd,        // Start/sync command pulse.
  input wire logic i_sleep_cmd,        // Power-down command pulse.
  input wire logic i_conv_tick,        // One pulse per conversion-clock cycle.
  input wire logic i_data_read,        // Host has read the sample.
  input wire logic i_serial_dout,      // Serial data bit for the combined pin.
  output acr_cfg_t o_cfg,              // Decoded configuration.
  output logic o_switch_closed,        // Low-side switch closed.
  output logic o_dedicated_ready_pin_n,      // Dedicated ready pin, active low.
  output logic o_combined_dataout_ready_pin  // Combined data-out/ready pin.
);

  logic [7:0] rate_mode_reg;
  logic [7:0] ref_cfg_reg;
  logic [7:0] route_cfg_reg;
  logic [7:0] next_rate_mode_reg;
  logic [7:0] next_ref_cfg_reg;
  logic [7:0] next_route_cfg_reg;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  acr_cfg_t cfg;
  acr_cfg_t next_cfg;
  logic switch_closed;
  logic next_switch_closed;
  logic combined_pin;
  logic next_combined_pin;
  logic ready_n;
  logic ready_pin_n;
  logic next_ready_pin_n;
  logic running;
  logic [2:0] rate_code;
  logic [1:0] mode_code;
  logic ready_mode;

  assign rate_code = rate_mode_reg[ACR_RATE_LSB +: 3];
  assign mode_code = rate_mode_reg[ACR_MODE_LSB +: 2];
  assign ready_mode = route_cfg_reg[ACR_READY_SIGNALLING_MODE_BIT];

  // Both current sources share one routing decode.
  function automatic logic [6:0] route_decode(input logic [2:0] code);
    logic [6:0] r;
    r = 7'h00;
    unique case (code)
      3'h0: r = 7'h00;
      3'h1: r = 7'h01;
      3'h2: r = 7'h02;
      3'h3: r = 7'h04;
      3'h4: r = 7'h08;
      3'h5: r = 7'h10;
      3'h6: r = 7'h20;
      3'h7: r = 7'h40;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Register file
  // ==========================================================================
  // Every bit is read/write; the reserved routing bit is stored as written.
  always_comb begin
    next_rate_mode_reg = rate_mode_reg;
    next_ref_cfg_reg = ref_cfg_reg;
    next_route_cfg_reg = route_cfg_reg;
    next_rdata = rdata;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        ACR_ADDR_RATE_MODE: next_rate_mode_reg = i_reg_wdata;
        ACR_ADDR_REF_CFG: next_ref_cfg_reg = i_reg_wdata;
        ACR_ADDR_ROUTE_CFG: next_route_cfg_reg = i_reg_wdata;
        default: next_rdata = rdata;
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        ACR_ADDR_RATE_MODE: next_rdata = rate_mode_reg;
        ACR_ADDR_REF_CFG: next_rdata = ref_cfg_reg;
        ACR_ADDR_ROUTE_CFG: next_rdata = route_cfg_reg;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rate_mode_reg <= ACR_REG_RESET;
      ref_cfg_reg <= ACR_REG_RESET;
      route_cfg_reg <= ACR_REG_RESET;
      rdata <= 8'h00;
    end else begin
      rate_mode_reg <= next_rate_mode_reg;
      ref_cfg_reg <= next_ref_cfg_reg;
      route_cfg_reg <= next_route_cfg_reg;
      rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // Configuration decode
  // ==========================================================================
  // Decoded fields are registered so every output comes from a flip-flop;
  // the cost is one cycle of latency after a register write.
  always_comb begin
    logic [19:0] base;
    logic [6:0] r1;
    logic [6:0] r2;
    base = 20'h0_0000;
    r1 = route_decode(route_cfg_reg[ACR_ROUTE1_LSB +: 3]);
    r2 = route_decode(route_cfg_reg[ACR_ROUTE2_LSB +: 3]);
    next_cfg = '0;
    // Reserved rate or mode leaves the period at zero, so nothing converts.
    if (rate_code != ACR_RATE_RESERVED) begin
      base = ACR_NORMAL_PERIOD[rate_code];
    end
    unique case (mode_code)
      ACR_MODE_NORMAL: next_cfg.period = base;
      ACR_MODE_DUTY: next_cfg.period = 20'({base, 2'b00});
      ACR_MODE_TURBO: next_cfg.period = {1'b0, base[19:1]};
      default: next_cfg.period = 20'h0_0000;
    endcase
    next_cfg.period = 20'(next_cfg.period / RATE_DIV);
    next_cfg.rate_reserved = (next_cfg.period == 20'h0_0000);
    unique case (ref_cfg_reg[ACR_VREF_LSB +: 2])
      2'h0: next_cfg.ref_sel = 4'h1;
      2'h1: next_cfg.ref_sel = 4'h2;
      2'h2: next_cfg.ref_sel = 4'h4;
      2'h3: next_cfg.ref_sel = 4'h8;
    endcase
    unique case (ref_cfg_reg[ACR_FIR_LSB +: 2])
      2'h0: next_cfg.fir_sel = 3'h0;
      2'h1: next_cfg.fir_sel = 3'h1;
      2'h2: next_cfg.fir_sel = 3'h2;
      2'h3: next_cfg.fir_sel = 3'h4;
    endcase
    next_cfg.excite_ua = ACR_IDAC_UA[ref_cfg_reg[ACR_IDAC_LSB +: 3]];
    next_cfg.excite_reserved = (ref_cfg_reg[ACR_IDAC_LSB +: 3] == ACR_IDAC_RESERVED);
    next_cfg.route_one = r1[5:0];
    next_cfg.route_one_reserved = r1[6];
    next_cfg.route_two = r2[5:0];
    next_cfg.route_two_reserved = r2[6];
  end

  // ==========================================================================
  // Switch and ready pins
  // ==========================================================================
  // The switch follows the commands only while its control bit is set.
  always_comb begin
    next_switch_closed = switch_closed;
    // Both ready pins register ready_n in the same stage; the combined pin follows it only while the mode bit is set and the timer runs.
    next_ready_pin_n = ready_n;
    if (!ref_cfg_reg[ACR_PSW_BIT]) begin
      next_switch_closed = 1'b0;
    end else if (i_sleep_cmd) begin
      next_switch_closed = 1'b0;
    end else if (i_start_cmd) begin
      next_switch_closed = 1'b1;
    end
    // With the mode bit set the combined pin shows ready while data waits.
    next_combined_pin = i_serial_dout;
    if (ready_mode && !running) begin
      next_combined_pin = 1'b1;
    end else if (ready_mode) begin
      next_combined_pin = ready_n ? i_serial_dout : 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cfg <= '0;
      switch_closed <= 1'b0;
      combined_pin <= 1'b1;
      ready_pin_n <= 1'b1;
    end else begin
      cfg <= next_cfg;
      switch_closed <= next_switch_closed;
      combined_pin <= next_combined_pin;
      ready_pin_n <= next_ready_pin_n;
    end
  end

  acr_sample_timer u_timer (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(i_start_cmd),
    .i_sleep(i_sleep_cmd),
    .i_conv_tick(i_conv_tick),
    .i_period(cfg.period),            // Counted in conversion ticks.
    .i_data_read(i_data_read),
    .o_ready_n(ready_n),
    .o_running(running)
  );

  assign o_reg_rdata = rdata;
  assign o_cfg = cfg;
  assign o_switch_closed = switch_closed;
  assign o_dedicated_ready_pin_n = ready_pin_n;
  assign o_combined_dataout_ready_pin = combined_pin;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence write_ref_s(logic [7:0] v);
    i_reg_wr && i_reg_addr == ACR_ADDR_REF_CFG && i_reg_wdata == v;
  endsequence

  switch_open_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !ref_cfg_reg[ACR_PSW_BIT] |=> !switch_closed)
    else $error("switch closed with its control bit clear");

  switch_start_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ref_cfg_reg[ACR_PSW_BIT] && i_start_cmd && !i_sleep_cmd |=> switch_closed)
    else $error("switch did not close on start");

  ref_internal_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    write_ref_s(8'h00) |=> ##1 cfg.ref_sel == 4'h1 && cfg.excite_ua == 11'h000)
    else $error("reset reference decode wrong");

  ref_shared_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    write_ref_s(8'h87) |=> ##1 cfg.ref_sel == 4'h4 && cfg.excite_ua == 11'h5DC)
    else $error("shared reference or top current decode wrong");

  turbo_rate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_reg_wr && i_reg_addr == ACR_ADDR_RATE_MODE && i_reg_wdata == 8'hD0
    |=> ##1 cfg.period == 20'(20'h0_0800 / RATE_DIV))
    else $error("fastest turbo period wrong");

  reserved_mode_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    mode_code == 2'h3 |=> cfg.rate_reserved && cfg.period == 20'h0_0000)
    else $error("reserved mode not flagged");

  route_three_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    route_cfg_reg[ACR_ROUTE1_LSB +: 3] == 3'h4 |=> cfg.route_one == 6'h08)
    else $error("routing to input three wrong");

  ready_plain_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !ready_mode |=> combined_pin == $past(i_serial_dout))
    else $error("combined pin signalled ready with mode bit clear");

  readback_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_reg_rd && !i_reg_wr && i_reg_addr == ACR_ADDR_ROUTE_CFG |=> rdata == $past(route_cfg_reg))
    else $error("routing register readback wrong");

  pins_together_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $past(ready_mode) && !ready_pin_n |-> !combined_pin)
    else $error("combined pin did not signal ready with the dedicated pin");

endmodule

// File: hw/acr_pkg.sv
/*
  Shared constants and types for the converter configuration block: register
  offsets, field positions, reset values, mode codes, rate periods and the
  decoded configuration carrier.
  Assumes the conversion clock runs at a nominal 4.096 MHz, and that register
  accesses arrive as already-decoded single-cycle strobes from the serial port.
*/
package acr_pkg;

  // ==========================================================================
  // Register offsets and reset value
  // ==========================================================================
  localparam logic [1:0] ACR_ADDR_RATE_MODE = 2'h1;
  localparam logic [1:0] ACR_ADDR_REF_CFG = 2'h2;
  localparam logic [1:0] ACR_ADDR_ROUTE_CFG = 2'h3;
  localparam logic [7:0] ACR_REG_RESET = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int ACR_RATE_LSB = 5;
  localparam int ACR_MODE_LSB = 3;
  localparam int ACR_VREF_LSB = 6;
  localparam int ACR_FIR_LSB = 4;
  localparam int ACR_PSW_BIT = 3;
  localparam int ACR_IDAC_LSB = 0;
  localparam int ACR_ROUTE1_LSB = 5;
  localparam int ACR_ROUTE2_LSB = 2;
  localparam int ACR_READY_SIGNALLING_MODE_BIT = 1;

  // ==========================================================================
  // Mode and field codes
  // ==========================================================================
  localparam logic [1:0] ACR_MODE_NORMAL = 2'h0;
  localparam logic [1:0] ACR_MODE_DUTY = 2'h1;
  localparam logic [1:0] ACR_MODE_TURBO = 2'h2;
  localparam logic [2:0] ACR_RATE_RESERVED = 3'h7;
  localparam logic [2:0] ACR_IDAC_RESERVED = 3'h1;
  localparam logic [2:0] ACR_ROUTE_RESERVED = 3'h7;

  // ==========================================================================
  // Timing: samples are paced in conversion-clock cycles
  // ==========================================================================
  localparam int ACR_NOMINAL_CLK_KHZ = 4096;
  // Normal-mode sample periods at the nominal clock, rounded to whole cycles.
  localparam logic [19:0] ACR_NORMAL_PERIOD [0:6] = '{
    20'h3_2000, 20'h1_638E, 20'h0_B1C7, 20'h0_5B6E,
    20'h0_307C, 20'h0_1AAB, 20'h0_1000
  };

  // Excitation currents in microamps, indexed by level code.
  localparam logic [10:0] ACR_IDAC_UA [0:7] = '{
    11'h000, 11'h000, 11'h032, 11'h064, 11'h0FA, 11'h1F4, 11'h3E8, 11'h5DC
  };

  // ==========================================================================
  // Decoded configuration carrier
  // ==========================================================================
  typedef struct packed {
    logic [19:0] period;        // Conversion-clock cycles per sample, 0 = none.
    logic rate_reserved;        // Rate or mode code is reserved.
    logic [3:0] ref_sel;        // One-hot: supply, shared pair, pair 0, internal.
    logic [2:0] fir_sel;        // One-hot: 60 only, 50 only, both.
    logic [10:0] excite_ua;     // Current of both sources in microamps.
    logic excite_reserved;      // Level code is reserved.
    logic [5:0] route_one;      // One-hot: negative_reference_zero, positive_reference_zero, ain3, ain2, ain1, ain0.
    logic route_one_reserved;   // First routing code is reserved.
    logic [5:0] route_two;      // Same layout for the second source.
    logic route_two_reserved;   // Second routing code is reserved.
  } acr_cfg_t;

endpackage

// File: hw/acr_sample_timer.sv
/*
  Sample pacing for the converter: counts conversion-clock ticks between
  samples and drives the active-low data-ready level.
  Assumes i_conv_tick is a one-cycle pulse per conversion-clock cycle, already
  synchronous to i_clk, and that i_period is stable while running.
*/
`timescale 1ns/1ps
module acr_sample_timer
  import acr_pkg::*;
(
  input wire logic i_clk,           // System clock.
  input wire logic i_sys_rst,       // Synchronous reset, active high.
  input wire logic i_start,         // Conversion start command pulse.
  input wire logic i_sleep,         // Power-down command pulse.
  input wire logic i_conv_tick,     // One pulse per conversion-clock cycle.
  input wire logic [19:0] i_period, // Ticks per sample, 0 for reserved codes.
  input wire logic i_data_read,     // Host has read the sample.
  output logic o_ready_n,           // Data ready, low while a sample waits.
  output logic o_running            // High while converting.
);

  typedef enum logic [1:0] {
    ACR_ST_IDLE = 2'b01,
    ACR_ST_RUN = 2'b10
  } acr_state_t;

  acr_state_t state;
  acr_state_t next_state;
  logic [19:0] cnt;
  logic [19:0] next_cnt;
  logic ready_n;
  logic next_ready_n;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // A fresh sample wins over a read in the same cycle, so no sample is lost.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ready_n = ready_n;
    if (i_data_read) begin
      next_ready_n = 1'b1;
    end
    unique case (state)
      ACR_ST_IDLE: begin
        if (i_start && i_period != 20'h0_0000) begin
          next_state = ACR_ST_RUN;
          next_cnt = 20'h0_0000;
        end
      end
      ACR_ST_RUN: begin
        if (i_sleep || i_period == 20'h0_0000) begin
          next_state = ACR_ST_IDLE;
          next_ready_n = 1'b1;
        end else if (i_start) begin
          next_cnt = 20'h0_0000;
        end else if (i_conv_tick) begin
          // Counting clock ticks makes the rate follow the clock.
          if (20'(cnt + 20'h0_0001) >= i_period) begin
            next_cnt = 20'h0_0000;
            next_ready_n = 1'b0;
          end else begin
            next_cnt = 20'(cnt + 20'h0_0001);
          end
        end
      end
    endcase
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= ACR_ST_IDLE;
      cnt <= 20'h0_0000;
      ready_n <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ready_n <= next_ready_n;
    end
  end

  assign o_ready_n = ready_n;
  assign o_running = (state == ACR_ST_RUN);

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence tick_in_run_s;
    i_conv_tick && state == ACR_ST_RUN && !i_sleep && !i_start && i_period != 20'h0_0000;
  endsequence

  ready_from_tick_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(ready_n) |-> $past(i_conv_tick) && $past(state == ACR_ST_RUN))
    else $error("data ready fell without a conversion tick");

  period_reach_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    tick_in_run_s ##0 (20'(cnt + 20'h0_0001) >= i_period) |=> !ready_n && cnt == 20'h0_0000)
    else $error("sample not flagged when the period elapsed");

  sleep_stops_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_sleep |=> state == ACR_ST_IDLE && ready_n)
    else $error("power-down did not stop conversions");

endmodule

// File: testbench/acr_host_model.sv
/*
  Host model: drives register strobes and command pulses into the block.
  Assumes one clock shared with the block and a caller that waits for reset.
*/
`timescale 1ns/1ps
module acr_host_model
  import acr_pkg::*;
(
  input wire logic i_clk,       // System clock.
  output logic o_wr = 1'b0,     // Write strobe.
  output logic o_rd = 1'b0,     // Read strobe.
  output logic [1:0] o_addr = 2'h0, // Register offset.
  output logic [7:0] o_wdata = 8'h00, // Write byte.
  output logic o_start = 1'b0,  // Start command pulse.
  output logic o_sleep = 1'b0   // Power-down command pulse.
);
  logic [7:0] rate_reg = 8'h00;
  // ==========================================================
  // Bus tasks
  // ==========================================================
  // One strobe per call; the idle edge after it avoids double assignment.
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (w && a == ACR_ADDR_ROUTE_CFG) v[0] = 1'b0;
    // Filter codes stay at zero unless the rate is the slowest one in normal or duty mode.
    if (w && a == ACR_ADDR_REF_CFG && (rate_reg[7:5] != 3'h0 || rate_reg[4])) v[5:4] = 2'h0;
    if (w && a == ACR_ADDR_RATE_MODE) rate_reg = v;
    @(posedge i_clk);
    o_wr <= w;
    o_rd <= !w;
    o_addr <= a;
    o_wdata <= v;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
  endtask
  // Command pulse: start when s is high, power-down otherwise.
  task automatic pulse(input logic s);
    @(posedge i_clk);
    o_start <= s;
    o_sleep <= !s;
    @(posedge i_clk);
    o_start <= 1'b0;
    o_sleep <= 1'b0;
  endtask
endmodule

// File: testbench/acr_config_regs_tb.sv
/*
  Self-checking bench for the configuration block with a host model.
  Assumes RATE_DIV of 256 so that the fastest turbo period is 8 ticks.
*/
`timescale 1ns/1ps
module acr_config_regs_tb
  import acr_pkg::*;
;
  logic clk, rst, wr, rd, st, slp, tick, dread, dout, rd_q, sw, rdy_n, comb;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [31:0] seed = 32'h0000_2def;
  logic [31:0] r;
  acr_cfg_t cfg;
  int fail_count = 0;
  int compares = 0;
  int n;
  logic [7:0] expq[$];
  int ua[8] = '{0, 0, 50, 100, 250, 500, 1000, 1500};
  logic [7:0] rv[4] = '{8'hE0, 8'h18, 8'h08, 8'hD0};
  int pv[4] = '{0, 0, 3200, 8};
  acr_host_model u_host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .o_start(st), .o_sleep(slp));
  acr_config_regs #(.RATE_DIV(256)) u_dut (.i_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_start_cmd(st), .i_sleep_cmd(slp), .i_conv_tick(tick), .i_data_read(dread),
    .i_serial_dout(dout), .o_cfg(cfg), .o_switch_closed(sw),
    .o_dedicated_ready_pin_n(rdy_n), .o_combined_dataout_ready_pin(comb));
  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [5:0] rt(input logic [2:0] c);
    return (c == 3'h0 || c == 3'h7) ? 6'h00 : 6'h01 << (c - 3'h1);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdx(input logic [1:0] a, input logic [7:0] e);
    expq.push_back(e);
    u_host.acc(1'b0, a, 8'h00);
  endtask
  // Registered decode lags a write by two edges, so wait that long.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Bounded wait for the ready pin, counting edges.
  task automatic wait_ready();
    n = 0;
    while (rdy_n !== 1'b0 && n < 30) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Clock, monitor and watchdog
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Read data lands one edge after the strobe; the oldest note is compared.
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q === 1'b1) begin
      if (expq.size() == 0) chk("unexpected read", 32'h1, 32'h0);
      else chk("rdata", rdata, expq.pop_front());
    end
  end
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {tick, dread, dout} = 3'h0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk("period", cfg.period, 32'h0000_0320);
    chk("ref", cfg.ref_sel, 4'h1);
    rdx(2'h2, 8'h00);
    rdx(2'h3, 8'h00);
    // Sweep every code of every reference and routing field; switch bit and ready bit are random.
    for (int i = 0; i < 8; i++) begin
      r = xs();
      v = {i[1:0], i[1:0], r[0], i[2:0]};
      u_host.acc(1'b1, 2'h2, v);
      settle();
      chk("ref", cfg.ref_sel, 4'h1 << i[1:0]);
      chk("fir", cfg.fir_sel, i[1:0] == 0 ? 3'h0 : 3'h1 << (i[1:0] - 1));
      chk("ua", cfg.excite_ua, ua[i]);
      chk("ua res", cfg.excite_reserved, i == 1);
      rdx(2'h2, v);
      v = {i[2:0], 3'(7 - i), r[1], 1'b0};
      u_host.acc(1'b1, 2'h3, v);
      settle();
      chk("route1", cfg.route_one, rt(i[2:0]));
      chk("route2", cfg.route_two, rt(3'(7 - i)));
      chk("route1 res", cfg.route_one_reserved, i == 7);
      chk("route2 res", cfg.route_two_reserved, i == 0);
      rdx(2'h3, v);
    end
    u_host.acc(1'b1, 2'h0, 8'hFF);
    rdx(2'h0, 8'h00);
    // Shared reference at top current, then filter back to 00 before rates change.
    u_host.acc(1'b1, 2'h2, 8'h87);
    settle();
    chk("ref", cfg.ref_sel, 4'h4);
    chk("ua", cfg.excite_ua, 1500);
    u_host.acc(1'b1, 2'h2, 8'h00);
    // Reserved rate, reserved mode, slowest duty rate, fastest turbo rate.
    for (int k = 0; k < 4; k++) begin
      u_host.acc(1'b1, 2'h1, rv[k]);
      settle();
      chk("period", cfg.period, pv[k]);
      chk("rate res", cfg.rate_reserved, k < 2);
      rdx(2'h1, rv[k]);
    end
    // Switch enabled, ready signalled on both pins.
    u_host.acc(1'b1, 2'h2, 8'h08);
    u_host.acc(1'b1, 2'h3, 8'h02);
    @(posedge clk);
    tick <= 1'b1;
    dout <= r[2];
    u_host.pulse(1'b1);
    wait_ready();
    chk("ready wait", n >= 6 && n <= 11, 1);
    chk("switch", sw, 1'b1);
    chk("combined", comb, 1'b0);
    @(posedge clk);
    dread <= 1'b1;
    @(posedge clk);
    dread <= 1'b0;
    @(posedge clk);
    #1;
    chk("ready", rdy_n, 1'b1);
    u_host.pulse(1'b0);
    #1;
    chk("switch", sw, 1'b0);
    // Switch disabled, combined pin carries data only.
    u_host.acc(1'b1, 2'h2, 8'h00);
    u_host.acc(1'b1, 2'h3, 8'h00);
    u_host.pulse(1'b1);
    dout <= 1'b1;
    wait_ready();
    chk("ready", rdy_n, 1'b0);
    chk("switch", sw, 1'b0);
    chk("combined", comb, dout);
    settle();
    wrap_up();
  end
endmodule
